/* File: bus_conditions.sv */
/*
  Edge and bus condition detector for the synchronised clock and data lines.
  Assumes both inputs already passed the same synchroniser depth.
*/
module bus_conditions (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_s,
  input wire logic sda_s,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_det,
  output logic stop_det
);
  logic scl_prev_reg;
  logic sda_prev_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  // data moving while clock stays high marks start or stop
  assign scl_rise = scl_s & ~scl_prev_reg;
  assign scl_fall = ~scl_s & scl_prev_reg;
  assign start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  assign stop_det = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
endmodule : bus_conditions

/* File: dac_i2c_slave_frontend.sv */
/*
  Two-wire slave front end of the 10-bit current-sink DAC: address decode,
  acknowledge, two-byte input word, transfer to the DAC register, read back
  with clear, soft and pin power-down gating of the output code.
  Assumes an open-drain bus resolved outside, pull-ups, and a master clock
  no faster than the system clock can oversample (10 MHz against 400 kHz).
*/
module dac_i2c_slave_frontend (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic power_down_n,
  output logic [9:0] dac_code,
  output logic sink_on,
  output logic [15:0] dac_word
);
  localparam int CLK_NS = dac_serial_pkg::CLK_PERIOD_NS;

  if (dac_serial_pkg::SCL_HIGH_MIN_CYC <= dac_serial_pkg::DETECT_LATENCY_CYC) begin : high_phase_check
    $error("clock too slow to oversample the serial clock high phase");
  end
  if (dac_serial_pkg::SCL_LOW_MIN_CYC <= 2 * dac_serial_pkg::DETECT_LATENCY_CYC) begin : low_phase_check
    $error("clock too slow to meet data setup in the serial clock low phase");
  end
  if (CLK_NS <= 0) begin : period_check
    $error("clock period must be positive");
  end

  logic scl_s;
  logic sda_s;
  logic pd_n_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  dac_serial_pkg::bus_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [1:0] byte_idx_reg;
  logic [7:0] shift_reg;
  logic rw_reg;
  logic [15:0] input_word_reg;
  logic sda_oe_reg;
  logic sda_o_reg;
  logic [15:0] dac_reg;
  logic [9:0] dac_code_reg;
  logic sink_on_reg;

  sync_stage #(
    .WIDTH(3),
    .RESET_VAL(3'h7)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in({scl_i, sda_i, power_down_n}),
    .sync_out({scl_s, sda_s, pd_n_s})
  );

  bus_conditions u_cond (
    .clk(clk),
    .rst(rst),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  // bit of the word sent next: high byte first, MSB first
  function automatic logic word_bit(input logic [15:0] word, input logic [1:0] byte_idx, input logic [3:0] cnt);
    logic [3:0] pos;
    pos = 4'hF - {byte_idx[0], cnt[2:0]};
    return word[pos];
  endfunction : word_bit

  logic byte_end;
  logic addr_match;
  logic frame_break;
  logic wr_load;
  logic read_done;
  logic mack_continue;

  assign frame_break = start_det | stop_det;
  assign byte_end = scl_fall & (bit_cnt_reg == dac_serial_pkg::BITS_PER_BYTE);
  assign addr_match = shift_reg[dac_serial_pkg::ADDR_PREFIX_MSB:dac_serial_pkg::ADDR_PREFIX_LSB]
                      == dac_serial_pkg::ADDR_PREFIX;
  assign wr_load = ~frame_break & (state_reg == dac_serial_pkg::ST_WR) & byte_end
                   & (byte_idx_reg == dac_serial_pkg::DATA_BYTES - 2'h1);
  assign read_done = ~frame_break & (state_reg == dac_serial_pkg::ST_MACK) & scl_rise
                     & (byte_idx_reg == dac_serial_pkg::DATA_BYTES - 2'h1);
  assign mack_continue = ~frame_break & (state_reg == dac_serial_pkg::ST_MACK) & scl_fall
                         & (byte_idx_reg == dac_serial_pkg::DATA_BYTES - 2'h1);

  // protocol sequencing; a start anywhere restarts, a stop always idles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= dac_serial_pkg::ST_IDLE;
      bit_cnt_reg <= 4'h0;
      byte_idx_reg <= 2'h0;
      shift_reg <= 8'h00;
      rw_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= dac_serial_pkg::ST_ADDR;
      bit_cnt_reg <= 4'h0;
      byte_idx_reg <= 2'h0;
    end else if (stop_det) begin
      state_reg <= dac_serial_pkg::ST_IDLE;
    end else begin
      unique case (state_reg)
        dac_serial_pkg::ST_IDLE: begin
        end
        dac_serial_pkg::ST_ADDR: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_end) begin
            rw_reg <= shift_reg[dac_serial_pkg::RW_BIT];
            state_reg <= addr_match ? dac_serial_pkg::ST_ACK : dac_serial_pkg::ST_WAIT;
          end
        end
        dac_serial_pkg::ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            state_reg <= rw_reg ? dac_serial_pkg::ST_RD : dac_serial_pkg::ST_WR;
          end
        end
        dac_serial_pkg::ST_WR: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_end) begin
            // a third data byte is refused: no ack, wait for stop
            if (byte_idx_reg < dac_serial_pkg::DATA_BYTES) begin
              byte_idx_reg <= byte_idx_reg + 2'h1;
              state_reg <= dac_serial_pkg::ST_ACK;
            end else begin
              state_reg <= dac_serial_pkg::ST_WAIT;
            end
          end
        end
        dac_serial_pkg::ST_RD: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_end) begin
            state_reg <= dac_serial_pkg::ST_MACK;
          end
        end
        dac_serial_pkg::ST_MACK: begin
          if (scl_rise) begin
            if (read_done || sda_s) begin
              state_reg <= dac_serial_pkg::ST_WAIT;
            end else begin
              byte_idx_reg <= byte_idx_reg + 2'h1;
            end
          end else if (mack_continue) begin
            bit_cnt_reg <= 4'h0;
            state_reg <= dac_serial_pkg::ST_RD;
          end
        end
        dac_serial_pkg::ST_WAIT: begin
        end
      endcase
    end
  end

  // data line drive: only ever pulled low, released otherwise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_oe_reg <= 1'b0;
    end else if (frame_break) begin
      sda_oe_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        dac_serial_pkg::ST_ADDR: begin
          if (byte_end) sda_oe_reg <= addr_match;
        end
        dac_serial_pkg::ST_ACK: begin
          if (scl_fall) begin
            sda_oe_reg <= rw_reg ? ~word_bit(input_word_reg, 2'h0, 4'h0) : 1'b0;
          end
        end
        dac_serial_pkg::ST_WR: begin
          if (byte_end) sda_oe_reg <= byte_idx_reg < dac_serial_pkg::DATA_BYTES;
        end
        dac_serial_pkg::ST_RD: begin
          if (byte_end) begin
            sda_oe_reg <= 1'b0;
          end else if (scl_fall) begin
            sda_oe_reg <= ~word_bit(input_word_reg, byte_idx_reg, bit_cnt_reg);
          end
        end
        dac_serial_pkg::ST_MACK: begin
          if (mack_continue) sda_oe_reg <= ~word_bit(input_word_reg, 2'h1, 4'h0);
        end
        default: begin
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_o_reg <= 1'b0;
    end else begin
      sda_o_reg <= 1'b0;
    end
  end

  // input word: shifted during writes, cleared once the second read byte completes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      input_word_reg <= dac_serial_pkg::WORD_RESET;
    end else if (read_done) begin
      input_word_reg <= dac_serial_pkg::WORD_RESET;
    end else if (~frame_break && state_reg == dac_serial_pkg::ST_WR && scl_rise
                 && byte_idx_reg < dac_serial_pkg::DATA_BYTES) begin
      input_word_reg <= {input_word_reg[14:0], sda_s};
    end
  end

  // a partial write never reaches the converter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dac_reg <= dac_serial_pkg::WORD_RESET;
    end else if (wr_load) begin
      dac_reg <= input_word_reg;
    end
  end

  // output stage gating; the pin acts without the clock, the synced copy
  // keeps the output off until the release has been seen on clk
  always_ff @(posedge clk or posedge rst or negedge power_down_n) begin
    if (rst) begin
      dac_code_reg <= dac_serial_pkg::CODE_OFF;
      sink_on_reg <= 1'b0;
    end else if (!power_down_n) begin
      dac_code_reg <= dac_serial_pkg::CODE_OFF;
      sink_on_reg <= 1'b0;
    end else if (!pd_n_s || dac_reg[dac_serial_pkg::SOFT_PD_BIT]) begin
      dac_code_reg <= dac_serial_pkg::CODE_OFF;
      sink_on_reg <= 1'b0;
    end else begin
      dac_code_reg <= dac_reg[dac_serial_pkg::CODE_MSB:dac_serial_pkg::CODE_LSB];
      sink_on_reg <= 1'b1;
    end
  end

  assign sda_o = sda_o_reg;
  assign sda_oe = sda_oe_reg;
  assign dac_code = dac_code_reg;
  assign sink_on = sink_on_reg;
  assign dac_word = dac_reg;

  sequence addr_byte_taken_s;
    state_reg == dac_serial_pkg::ST_ADDR && byte_end && !frame_break && addr_match;
  endsequence

  sequence ack_entered_s;
    state_reg == dac_serial_pkg::ST_ACK && sda_oe_reg;
  endsequence

  pin_power_down_a: assert property (@(posedge clk) disable iff (rst)
    !power_down_n |-> dac_code == dac_serial_pkg::CODE_OFF && !sink_on)
    else $error("output not off while power-down pin low");

  addr_ack_a: assert property (@(posedge clk) disable iff (rst)
    addr_byte_taken_s |=> ack_entered_s)
    else $error("matching address not acknowledged");

  addr_reject_a: assert property (@(posedge clk) disable iff (rst)
    state_reg == dac_serial_pkg::ST_ADDR && byte_end && !frame_break && !addr_match
    |=> state_reg == dac_serial_pkg::ST_WAIT && !sda_oe_reg)
    else $error("foreign address acknowledged");

  rw_direction_a: assert property (@(posedge clk) disable iff (rst)
    (ack_entered_s and (!frame_break && scl_fall))
    |=> state_reg == (rw_reg ? dac_serial_pkg::ST_RD : dac_serial_pkg::ST_WR))
    else $error("direction bit not followed");

  ack_hold_a: assert property (@(posedge clk) disable iff (rst)
    (ack_entered_s and (!scl_fall && !frame_break)) |=> sda_oe_reg)
    else $error("acknowledge released before ninth clock ended");

  third_byte_a: assert property (@(posedge clk) disable iff (rst)
    state_reg == dac_serial_pkg::ST_WR && byte_end && !frame_break
    && byte_idx_reg == dac_serial_pkg::DATA_BYTES |=> !sda_oe_reg)
    else $error("third data byte acknowledged");

  start_addr_a: assert property (@(posedge clk) disable iff (rst)
    start_det |=> state_reg == dac_serial_pkg::ST_ADDR && bit_cnt_reg == 4'h0)
    else $error("start did not open address phase");

  load_only_a: assert property (@(posedge clk) disable iff (rst)
    !$stable(dac_reg) |-> $past(wr_load))
    else $error("dac register changed without a full write");

  code_map_a: assert property (@(posedge clk) disable iff (rst)
    sink_on |-> dac_code == $past(dac_reg[13:4]))
    else $error("code does not follow word bits 13..4");

  soft_pd_a: assert property (@(posedge clk) disable iff (rst)
    power_down_n && $past(dac_reg[dac_serial_pkg::SOFT_PD_BIT]) |-> !sink_on && dac_code == 10'h000)
    else $error("soft power-down did not zero output");

  read_clear_a: assert property (@(posedge clk) disable iff (rst)
    read_done |=> input_word_reg == 16'h0000 ##1 state_reg != dac_serial_pkg::ST_RD)
    else $error("input word not cleared after read");

  read_bit_a: assert property (@(posedge clk) disable iff (rst)
    state_reg == dac_serial_pkg::ST_RD && scl_rise && bit_cnt_reg < 4'h8
    |-> sda_oe_reg == ~word_bit(input_word_reg, byte_idx_reg, bit_cnt_reg))
    else $error("read bit out of order");
endmodule : dac_i2c_slave_frontend

/* File: dac_i2c_slave_frontend_test.sv */
/*
  Self-checking bench for the two-wire slave front end of the 10-bit sink DAC.
  Assumes the master model drives the bus asynchronously to the 10 MHz clock.
*/
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("ERROR %0t: got %h expected %h", $time, got, exp); end end

module dac_i2c_slave_frontend_test;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk;
  logic rst;
  logic power_down_n;
  logic scl;
  logic m_low;
  logic sda;
  logic sda_o;
  logic sda_oe;
  logic sink_on;
  logic [9:0] dac_code;
  logic [15:0] dac_word;
  logic [15:0] rw;
  int n_mismatch;
  int cmp_count;

  // open-drain wire with pull-up
  assign sda = ~(m_low | sda_oe);

  i2c_master_model m (
    .scl(scl),
    .sda_low(m_low),
    .sda(sda)
  );

  dac_i2c_slave_frontend DUT (
    .clk(clk),
    .rst(rst),
    .scl_i(scl),
    .sda_i(sda),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .power_down_n(power_down_n),
    .dac_code(dac_code),
    .sink_on(sink_on),
    .dac_word(dac_word)
  );

  initial begin
    clk = 1'b0;
  end

  always #50 clk = ~clk;

  task automatic close_out();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  // bytes past the second are sent to see them refused
  task automatic wr(input logic [7:0] a, input logic [15:0] w, input int nb, input logic hit);
    logic ack;
    m.start_c();
    m.send_byte(a, ack);
    `CHECK(ack, hit)
    for (int i = 0; i < nb; i++) begin
      m.send_byte(i[0] ? w[7:0] : w[15:8], ack);
      `CHECK(ack, hit && (i < 2))
    end
    m.stop_c();
  endtask : wr

  task automatic rd(input logic one_byte, output logic [15:0] w);
    logic ack;
    m.start_c();
    m.send_byte(8'h19, ack);
    `CHECK(ack, 1'b1)
    // a refused first byte ends the read early and must leave the word in place
    m.recv_byte(one_byte, w[15:8]);
    w[7:0] = 8'h00;
    if (!one_byte) m.recv_byte(1'b1, w[7:0]);
    m.stop_c();
  endtask : rd

  initial begin
    #2000000;
    n_mismatch++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    power_down_n = 1'b1;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (8) @(posedge clk);
    #5 rst = 1'b0;
    repeat (4) @(posedge clk);
    #5;
    `CHECK(dac_word, 16'h0000)
    `CHECK(dac_code, 10'h000)
    `CHECK(sda_oe, 1'b0)
    `CHECK(sink_on, 1'b1)
    wr(8'h18, 16'h3A5F, 2, 1'b1);
    `CHECK(dac_word, 16'h3A5F)
    `CHECK(dac_code, 10'h3A5)
    `CHECK(sink_on, 1'b1)
    rd(1'b0, rw);
    `CHECK(rw, 16'h3A5F)
    rd(1'b0, rw);
    `CHECK(rw, 16'h0000)
    `CHECK(dac_word, 16'h3A5F)
    // a lone byte shifts in but must not reach the DAC register
    wr(8'h18, 16'hC0F0, 1, 1'b1);
    `CHECK(dac_word, 16'h3A5F)
    `CHECK(sink_on, 1'b1)
    for (int a = 0; a < 4; a++) begin
      wr({5'h03, a[1:0], 1'b0}, 16'(16'h1230 + a), 2, 1'b1);
      `CHECK(dac_word, 16'(16'h1230 + a))
    end
    wr(8'h10, 16'hFFFF, 2, 1'b0);
    wr(8'h38, 16'hFFFF, 2, 1'b0);
    `CHECK(dac_word, 16'h1233)
    wr(8'h18, 16'h7FFF, 3, 1'b1);
    `CHECK(dac_word, 16'h7FFF)
    `CHECK(dac_code, 10'h3FF)
    `CHECK(sink_on, 1'b1)
    wr(8'h18, 16'h8550, 2, 1'b1);
    `CHECK(dac_word, 16'h8550)
    `CHECK(dac_code, 10'h000)
    `CHECK(sink_on, 1'b0)
    wr(8'h18, 16'h0550, 2, 1'b1);
    `CHECK(dac_code, 10'h055)
    `CHECK(sink_on, 1'b1)
    @(posedge clk);
    #5 power_down_n = 1'b0;
    // no clock edge has passed yet
    #1;
    `CHECK(dac_code, 10'h000)
    `CHECK(sink_on, 1'b0)
    wr(8'h18, 16'h1110, 2, 1'b1);
    `CHECK(dac_word, 16'h1110)
    `CHECK(dac_code, 10'h000)
    @(posedge clk);
    #5 power_down_n = 1'b1;
    repeat (5) @(posedge clk);
    #5;
    `CHECK(dac_code, 10'h111)
    `CHECK(sink_on, 1'b1)
    `CHECK(sda_o, 1'b0)
    rd(1'b1, rw);
    `CHECK(rw, 16'h1100)
    rd(1'b0, rw);
    `CHECK(rw, 16'h1110)
    close_out();
  end
endmodule : dac_i2c_slave_frontend_test

/* File: dac_serial_pkg.sv */
/*
  Shared constants of the two-wire slave front end of the 10-bit sink DAC:
  address prefix, input word layout, reset values and bus timing figures.
  Assumes a 10 MHz system clock and a bus master at no more than 400 kHz.
*/
package dac_serial_pkg;
  // upper five address bits; the two low address bits are don't care
  localparam logic [4:0] ADDR_PREFIX = 5'h03;
  localparam int ADDR_PREFIX_MSB = 7;
  localparam int ADDR_PREFIX_LSB = 3;
  localparam int RW_BIT = 0;

  localparam int WORD_W = 16;
  localparam int CODE_W = 10;
  localparam int SOFT_PD_BIT = 15;
  localparam int CODE_MSB = 13;
  localparam int CODE_LSB = 4;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [9:0] CODE_OFF = 10'h000;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] DATA_BYTES = 2'h2;
  localparam int SYNC_STAGES = 2;

  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_HIGH_MIN_NS = 600;
  localparam int SCL_LOW_MIN_NS = 1300;
  // least times round up to whole cycles
  localparam int SCL_HIGH_MIN_CYC = (SCL_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCL_LOW_MIN_CYC = (SCL_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // synchroniser plus edge register latency the bus phases must outlast
  localparam int DETECT_LATENCY_CYC = SYNC_STAGES + 1;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_ACK  = 7'h04,
    ST_WR   = 7'h08,
    ST_RD   = 7'h10,
    ST_MACK = 7'h20,
    ST_WAIT = 7'h40
  } bus_state_t;
endpackage : dac_serial_pkg

/* File: i2c_master_model.sv */
/*
  Behavioural two-wire bus master driving the front end's clock and data lines.
  Assumes pull-ups on both lines; the bench resolves the data wire from all pull-downs.
*/
module i2c_master_model (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;

  // 800 ns bit period: 400 ns low, 400 ns high
  localparam int QTR = 100;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // clock stands high between frames; the idle gap also keeps the bus free time
  task automatic start_c();
    #1337;
    sda_low = 1'b1;
    #(4 * QTR);
    scl = 1'b0;
    #(3 * QTR);
  endtask : start_c

  // data moves 300 ns into the low phase so the device has already seen the fall
  task automatic bit_x(input logic drive_val, output logic got);
    sda_low = ~drive_val;
    #QTR;
    scl = 1'b1;
    // sample late in the high phase, long after the device answered the fall
    #(3 * QTR + 50);
    got = sda;
    #50;
    scl = 1'b0;
    #(3 * QTR);
  endtask : bit_x

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], g);
    end
    bit_x(1'b1, g);
    ack = ~g;
  endtask : send_byte

  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, b[i]);
    end
    // master acknowledges the read byte, or refuses it when last is set
    bit_x(last, g);
  endtask : recv_byte

  task automatic stop_c();
    sda_low = 1'b1;
    #QTR;
    scl = 1'b1;
    #(4 * QTR);
    sda_low = 1'b0;
    #(4 * QTR);
  endtask : stop_c
endmodule : i2c_master_model

/* File: sync_stage.sv */
/*
  Two-flop synchroniser for a group of independent level inputs.
  Assumes each bit is a slow level; no bus coherence is promised across bits.
*/
module sync_stage #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  if (WIDTH < 1) begin : width_check
    $error("sync_stage: WIDTH must be at least 1");
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : sync_stage
